//--- rtl/pcie_config_autoload.sv
// Power-up configuration loader and attribute-typed configuration registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - After power-up reset, fetch header values from EEPROM or defaults, then configure.
// - Read EEPROM byte 00h; load from EEPROM only when it equals 55h.
// - A responding EEPROM with a wrong tag is treated as absent.
// - Absent or invalid EEPROM: load nothing, use internal default values.
// - Image: tag, vendor, device, revision, subsystem vendor, subsystem; low bytes first.
// - Each function offers 4096 bytes of configuration space.
// - Offsets below 256 are legacy; 256 to 4095 form the extended region.
// - Memory-mapped access selects a register by address and returns its contents.
// - Hardware-initialised fields load once, then read-only until fundamental reset.
// - Read-only fields ignore writes; values come from straps or EEPROM.
// - Read-write fields return the last value software wrote.
// - Write-one-clear bits show events, clear on 1, unchanged on 0.
// - Sticky read-only fields survive hot reset; with aux power, warm and cold too.
// - Sticky write-one-clear bits clear by writing 1 or by warm or cold reset without aux power; survive resets with aux power.
// - Device is the two-wire master: drives clock, drives and samples data.
module pcie_config_autoload #(
	parameter logic [15:0] DEF_VENDOR_ID = 16'h0001, // Arbitrary value.
	parameter logic [15:0] DEF_DEVICE_ID = 16'h0002, // Arbitrary value.
	parameter logic [7:0] DEF_REVISION = 8'h00, // Arbitrary value.
	parameter logic [15:0] DEF_SUB_VENDOR_ID = 16'h0001, // Arbitrary value.
	parameter logic [15:0] DEF_SUB_ID = 16'h0003, // Arbitrary value.
	parameter logic [23:0] CLASS_CODE = 24'h070002,
	// A bench may shorten the serial bit time; the default keeps the bus near 100 kHz.
	parameter int QTR_CYC = cfg_autoload_pkg::QTR_CYC,
	parameter int EVT_W = 8
) (
	// Clock and resets
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic hot_reset_i,
	input wire logic warm_reset_i,
	input wire logic cold_reset_i,
	input wire logic aux_power_i,
	// EEPROM pins
	output logic eeprom_scl_o,
	input wire logic eeprom_sda_i,
	output logic eeprom_sda_o,
	output logic eeprom_sda_oe_n_o,
	// Status sources
	input wire logic [EVT_W-1:0] status_evt_i,
	input wire logic [EVT_W-1:0] sticky_evt_i,
	input wire logic [31:0] sticky_ro_strap_i,
	// Configuration access
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic [31:0] cfg_wdata_i,
	output logic cfg_ack_o,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_ext_o,
	output logic cfg_ready_o,
	output logic load_from_eeprom_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		cfg_autoload_pkg::ld_state_e st;
		logic [cfg_autoload_pkg::CNT_W-1:0] cnt;
		logic [1:0] ph;
		logic [2:0] bitc;
		logic [1:0] wstep;
		logic [3:0] idx;
		logic [7:0] sh;
		logic nak;
		logic ok;
		logic [cfg_autoload_pkg::IMG_BYTES-1:0][7:0] img;
		logic [2:0] sda_s;
		logic sda_f;
		logic scl;
		logic sda_oe_n;
		logic [15:0] vid;
		logic [15:0] did;
		logic [7:0] rev;
		logic [15:0] svid;
		logic [15:0] sid;
		logic ready;
		logic src_ee;
		logic [31:0] rw;
		logic [EVT_W-1:0] w1c;
		logic [31:0] srw;
		logic [EVT_W-1:0] sw1c;
		logic [31:0] sro;
		logic ack;
		logic [31:0] rdata;
		logic ext;
	} state_s;

	state_s q_ff;
	state_s nxt_q;
	logic tick;
	logic take;
	logic wr;
	logic sticky_rst;
	logic [EVT_W-1:0] clr_w1c;
	logic [EVT_W-1:0] clr_sw1c;
	logic [31:0] rd;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		nxt_q = q_ff;
		// Only the second and third stages are compared; the first may be metastable.
		nxt_q.sda_s = {q_ff.sda_s[1:0], eeprom_sda_i};
		if (q_ff.sda_s[1] == q_ff.sda_s[2]) begin
			nxt_q.sda_f = q_ff.sda_s[2];
		end
		tick = (q_ff.cnt == '0);
		nxt_q.cnt = tick ? cfg_autoload_pkg::CNT_W'(QTR_CYC - 1) : q_ff.cnt - 1'b1;
		if (tick) begin
			nxt_q.ph = q_ff.ph + 2'h1;
			case (q_ff.st)
				cfg_autoload_pkg::LD_IDLE: begin
					nxt_q.st = cfg_autoload_pkg::LD_START;
					nxt_q.ph = 2'h0;
				end
				cfg_autoload_pkg::LD_START: begin
					case (q_ff.ph)
						2'h1: nxt_q.sda_oe_n = 1'b0;
						2'h2: nxt_q.scl = 1'b0;
						2'h3: begin
							nxt_q.st = cfg_autoload_pkg::LD_WBIT;
							nxt_q.sh = cfg_autoload_pkg::CTRL_WR;
							nxt_q.wstep = cfg_autoload_pkg::WS_CTRL;
							nxt_q.bitc = 3'h0;
						end
						default: nxt_q.sda_oe_n = 1'b1;
					endcase
				end
				cfg_autoload_pkg::LD_WBIT: begin
					case (q_ff.ph)
						2'h0: nxt_q.sda_oe_n = q_ff.sh[7];
						2'h1: nxt_q.scl = 1'b1;
						2'h3: begin
							nxt_q.scl = 1'b0;
							nxt_q.sh = {q_ff.sh[6:0], 1'b0};
							nxt_q.bitc = q_ff.bitc + 3'h1;
							if (q_ff.bitc == cfg_autoload_pkg::LAST_BIT) begin
								nxt_q.st = cfg_autoload_pkg::LD_WACK;
							end
						end
						default: ;
					endcase
				end
				cfg_autoload_pkg::LD_WACK: begin
					case (q_ff.ph)
						2'h0: nxt_q.sda_oe_n = 1'b1;
						2'h1: nxt_q.scl = 1'b1;
						// A missing acknowledge means no EEPROM on the bus.
						2'h2: nxt_q.nak = q_ff.sda_f;
						default: begin
							nxt_q.scl = 1'b0;
							if (q_ff.nak) begin
								nxt_q.st = cfg_autoload_pkg::LD_STOP;
							end else if (q_ff.wstep == cfg_autoload_pkg::WS_CTRL) begin
								nxt_q.st = cfg_autoload_pkg::LD_WBIT;
								nxt_q.sh = cfg_autoload_pkg::IMG_START[15:8];
								nxt_q.wstep = cfg_autoload_pkg::WS_AHI;
							end else if (q_ff.wstep == cfg_autoload_pkg::WS_AHI) begin
								nxt_q.st = cfg_autoload_pkg::LD_WBIT;
								nxt_q.sh = cfg_autoload_pkg::IMG_START[7:0];
								nxt_q.wstep = cfg_autoload_pkg::WS_ALO;
							end else if (q_ff.wstep == cfg_autoload_pkg::WS_ALO) begin
								nxt_q.st = cfg_autoload_pkg::LD_RSTART;
							end else begin
								nxt_q.st = cfg_autoload_pkg::LD_RBIT;
								nxt_q.idx = cfg_autoload_pkg::IMG_TAG;
							end
						end
					endcase
				end
				cfg_autoload_pkg::LD_RSTART: begin
					case (q_ff.ph)
						2'h0: nxt_q.sda_oe_n = 1'b1;
						2'h1: nxt_q.scl = 1'b1;
						2'h2: nxt_q.sda_oe_n = 1'b0;
						default: begin
							nxt_q.scl = 1'b0;
							nxt_q.st = cfg_autoload_pkg::LD_WBIT;
							nxt_q.sh = cfg_autoload_pkg::CTRL_RD;
							nxt_q.wstep = cfg_autoload_pkg::WS_RD;
						end
					endcase
				end
				cfg_autoload_pkg::LD_RBIT: begin
					case (q_ff.ph)
						2'h0: nxt_q.sda_oe_n = 1'b1;
						2'h1: nxt_q.scl = 1'b1;
						2'h2: nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_f};
						default: begin
							nxt_q.scl = 1'b0;
							nxt_q.bitc = q_ff.bitc + 3'h1;
							if (q_ff.bitc == cfg_autoload_pkg::LAST_BIT) begin
								nxt_q.st = cfg_autoload_pkg::LD_RACK;
							end
						end
					endcase
				end
				cfg_autoload_pkg::LD_RACK: begin
					case (q_ff.ph)
						2'h0: begin
							nxt_q.img[q_ff.idx] = q_ff.sh;
							// A wrong tag ends the read at once, so nothing else is fetched.
							nxt_q.nak = (q_ff.idx == cfg_autoload_pkg::IMG_SID_HI) ||
								(q_ff.idx == cfg_autoload_pkg::IMG_TAG && q_ff.sh != cfg_autoload_pkg::LOAD_TAG);
							nxt_q.ok = (q_ff.idx == cfg_autoload_pkg::IMG_SID_HI);
							nxt_q.sda_oe_n = nxt_q.nak;
						end
						2'h1: nxt_q.scl = 1'b1;
						2'h2: ;
						default: begin
							nxt_q.scl = 1'b0;
							nxt_q.idx = q_ff.idx + 4'h1;
							nxt_q.st = q_ff.nak ? cfg_autoload_pkg::LD_STOP : cfg_autoload_pkg::LD_RBIT;
						end
					endcase
				end
				cfg_autoload_pkg::LD_STOP: begin
					case (q_ff.ph)
						2'h0: nxt_q.sda_oe_n = 1'b0;
						2'h1: nxt_q.scl = 1'b1;
						2'h2: nxt_q.sda_oe_n = 1'b1;
						default: nxt_q.st = cfg_autoload_pkg::LD_DONE;
					endcase
				end
				cfg_autoload_pkg::LD_DONE: begin
					// Identity fields are written once here and never by software.
					nxt_q.src_ee = q_ff.ok;
					if (q_ff.ok) begin
						nxt_q.vid = {q_ff.img[cfg_autoload_pkg::IMG_VID_HI], q_ff.img[cfg_autoload_pkg::IMG_VID_LO]};
						nxt_q.did = {q_ff.img[cfg_autoload_pkg::IMG_DID_HI], q_ff.img[cfg_autoload_pkg::IMG_DID_LO]};
						nxt_q.rev = q_ff.img[cfg_autoload_pkg::IMG_REV];
						nxt_q.svid = {q_ff.img[cfg_autoload_pkg::IMG_SVID_HI], q_ff.img[cfg_autoload_pkg::IMG_SVID_LO]};
						nxt_q.sid = {q_ff.img[cfg_autoload_pkg::IMG_SID_HI], q_ff.img[cfg_autoload_pkg::IMG_SID_LO]};
					end else begin
						nxt_q.vid = DEF_VENDOR_ID;
						nxt_q.did = DEF_DEVICE_ID;
						nxt_q.rev = DEF_REVISION;
						nxt_q.svid = DEF_SUB_VENDOR_ID;
						nxt_q.sid = DEF_SUB_ID;
					end
					nxt_q.sro = sticky_ro_strap_i;
					nxt_q.ready = 1'b1;
					nxt_q.st = cfg_autoload_pkg::LD_READY;
				end
				default: ;
			endcase
		end

		// Configuration access, held off until the header is complete.
		take = cfg_req_i && q_ff.ready && !q_ff.ack;
		wr = take && cfg_we_i;
		nxt_q.ack = take;
		rd = 32'h0;
		if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_ID[11:2]) begin
			rd = {q_ff.did, q_ff.vid};
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_REV[11:2]) begin
			rd = {CLASS_CODE, q_ff.rev};
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_SUB[11:2]) begin
			rd = {q_ff.sid, q_ff.svid};
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_RW[11:2]) begin
			rd = q_ff.rw;
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_W1C[11:2]) begin
			rd = {{(32-EVT_W){1'b0}}, q_ff.w1c};
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_SRW[11:2]) begin
			rd = q_ff.srw;
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_SW1C[11:2]) begin
			rd = {{(32-EVT_W){1'b0}}, q_ff.sw1c};
		end else if (cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_SRO[11:2]) begin
			rd = q_ff.sro;
		end
		if (take) begin
			nxt_q.rdata = cfg_we_i ? 32'h0 : rd;
			nxt_q.ext = (cfg_addr_i >= cfg_autoload_pkg::EXT_BASE);
		end

		// Writes to identity and strap fields are dropped silently.
		if (wr && cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_RW[11:2]) begin
			nxt_q.rw = cfg_wdata_i;
		end
		if (wr && cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_SRW[11:2]) begin
			nxt_q.srw = cfg_wdata_i;
		end
		clr_w1c = (wr && cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_W1C[11:2]) ? cfg_wdata_i[EVT_W-1:0] : '0;
		clr_sw1c = (wr && cfg_addr_i[11:2] == cfg_autoload_pkg::OFS_SW1C[11:2]) ? cfg_wdata_i[EVT_W-1:0] : '0;

		// Resets below fundamental: sticky fields hold through hot reset, and through warm or cold reset only with aux power.
		sticky_rst = (warm_reset_i || cold_reset_i) && !aux_power_i;
		if (hot_reset_i || warm_reset_i || cold_reset_i) begin
			nxt_q.rw = 32'h0;
			clr_w1c = '1;
		end
		if (sticky_rst) begin
			nxt_q.srw = 32'h0;
			nxt_q.sro = sticky_ro_strap_i;
			clr_sw1c = '1;
		end
		// Events win over a clear in the same cycle.
		nxt_q.w1c = (q_ff.w1c & ~clr_w1c) | status_evt_i;
		nxt_q.sw1c = (q_ff.sw1c & ~clr_sw1c) | sticky_evt_i;
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			q_ff <= '0;
			q_ff.st <= cfg_autoload_pkg::LD_IDLE;
			q_ff.scl <= 1'b1;
			q_ff.sda_oe_n <= 1'b1;
			q_ff.sda_s <= 3'h7;
			q_ff.sda_f <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign eeprom_scl_o = q_ff.scl;
	assign eeprom_sda_o = 1'b0;
	assign eeprom_sda_oe_n_o = q_ff.sda_oe_n;
	assign cfg_ack_o = q_ff.ack;
	assign cfg_rdata_o = q_ff.rdata;
	assign cfg_ext_o = q_ff.ext;
	assign cfg_ready_o = q_ff.ready;
	assign load_from_eeprom_o = q_ff.src_ee;

endmodule : pcie_config_autoload
`default_nettype wire

//--- rtl/cfg_autoload_pkg.sv
// Constants and types shared by the configuration autoloader.
package cfg_autoload_pkg;

	// ----------------------------------------
	// EEPROM image layout
	// ----------------------------------------
	localparam logic [7:0] LOAD_TAG = 8'h55;
	localparam logic [3:0] IMG_TAG = 4'h0;
	localparam logic [3:0] IMG_VID_LO = 4'h1;
	localparam logic [3:0] IMG_VID_HI = 4'h2;
	localparam logic [3:0] IMG_DID_LO = 4'h3;
	localparam logic [3:0] IMG_DID_HI = 4'h4;
	localparam logic [3:0] IMG_REV = 4'h5;
	localparam logic [3:0] IMG_SVID_LO = 4'h6;
	localparam logic [3:0] IMG_SVID_HI = 4'h7;
	localparam logic [3:0] IMG_SID_LO = 4'h8;
	localparam logic [3:0] IMG_SID_HI = 4'h9;
	localparam int IMG_BYTES = 10;
	localparam logic [15:0] IMG_START = 16'h0000;

	// ----------------------------------------
	// Two-wire bus
	// ----------------------------------------
	localparam logic [7:0] CTRL_WR = 8'ha0;
	localparam logic [7:0] CTRL_RD = 8'ha1;
	localparam int QTR_NS = 2500;
	localparam int CLK_NS = 8;
	localparam int QTR_CYC = QTR_NS / CLK_NS;
	localparam int CNT_W = 10;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [1:0] WS_CTRL = 2'h0;
	localparam logic [1:0] WS_AHI = 2'h1;
	localparam logic [1:0] WS_ALO = 2'h2;
	localparam logic [1:0] WS_RD = 2'h3;

	// ----------------------------------------
	// Configuration space
	// ----------------------------------------
	localparam int CFG_BYTES = 4096;
	localparam logic [11:0] EXT_BASE = 12'h100;
	localparam logic [11:0] OFS_ID = 12'h000;
	localparam logic [11:0] OFS_REV = 12'h008;
	localparam logic [11:0] OFS_SUB = 12'h02c;
	localparam logic [11:0] OFS_RW = 12'h100;
	localparam logic [11:0] OFS_W1C = 12'h104;
	localparam logic [11:0] OFS_SRW = 12'h108;
	localparam logic [11:0] OFS_SW1C = 12'h10c;
	localparam logic [11:0] OFS_SRO = 12'h110;

	typedef enum logic [3:0] {
		LD_IDLE = 4'h0,
		LD_START = 4'h1,
		LD_WBIT = 4'h2,
		LD_WACK = 4'h3,
		LD_RSTART = 4'h4,
		LD_RBIT = 4'h5,
		LD_RACK = 4'h6,
		LD_STOP = 4'h7,
		LD_DONE = 4'h8,
		LD_READY = 4'h9
	} ld_state_e;

endpackage : cfg_autoload_pkg

//--- verif/cfg_autoload_assertions.sv
// Port-level checks for the configuration autoloader.
`timescale 1ns/1ps
`default_nettype none
module cfg_autoload_assertions (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Configuration access
	input wire logic cfg_req_i,
	input wire logic cfg_we_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic cfg_ack_o,
	input wire logic [31:0] cfg_rdata_o,
	input wire logic cfg_ext_o,
	input wire logic cfg_ready_o,
	input wire logic load_from_eeprom_o,
	// EEPROM pins
	input wire logic eeprom_scl_o,
	input wire logic eeprom_sda_o,
	input wire logic eeprom_sda_oe_n_o
);
	// ----------------------------------------
	// Access and bus checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		cfg_req_i && cfg_ready_o && !cfg_ack_o;
	endsequence
	sequence s_hole_read;
		s_take ##0 (!cfg_we_i && cfg_addr_i >= 12'h114);
	endsequence
	chk_ack_follows: assert property (s_take |=> cfg_ack_o)
		else $error("no answer after a taken request");
	chk_ack_single: assert property (cfg_ack_o |=> !cfg_ack_o)
		else $error("answer longer than one cycle");
	chk_ack_ready: assert property (cfg_ack_o |-> $past(cfg_ready_o))
		else $error("answer before the load finished");
	chk_ext_region: assert property (s_take |=> cfg_ext_o == ($past(cfg_addr_i) >= 12'h100))
		else $error("region flag wrong");
	chk_hole_zero: assert property (s_hole_read |=> cfg_rdata_o == 32'h0)
		else $error("unmapped read not zero");
	chk_ready_held: assert property (cfg_ready_o |=> cfg_ready_o)
		else $error("ready dropped without reset");
	chk_source_fixed: assert property (cfg_ready_o |=> $stable(load_from_eeprom_o))
		else $error("load source changed after load");
	chk_bus_idle: assert property (cfg_ready_o |-> eeprom_scl_o && eeprom_sda_oe_n_o)
		else $error("bus not idle after load");
	chk_sda_drain: assert property (eeprom_sda_o == 1'b0)
		else $error("data pin driven high");
	chk_scl_low_hold: assert property ($fell(eeprom_scl_o) |-> (!eeprom_scl_o) [*8])
		else $error("serial clock low phase too short");
endmodule : cfg_autoload_assertions
bind pcie_config_autoload cfg_autoload_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.cfg_req_i(cfg_req_i), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i), .cfg_ack_o(cfg_ack_o),
	.cfg_rdata_o(cfg_rdata_o), .cfg_ext_o(cfg_ext_o), .cfg_ready_o(cfg_ready_o),
	.load_from_eeprom_o(load_from_eeprom_o), .eeprom_scl_o(eeprom_scl_o), .eeprom_sda_o(eeprom_sda_o),
	.eeprom_sda_oe_n_o(eeprom_sda_oe_n_o));
`default_nettype wire

//--- verif/eeprom_model.sv
// Behavioural two-wire EEPROM holding the identity image.
`timescale 1ns/1ps
`default_nettype none
module eeprom_model (
	// Bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	output logic pull_o,
	// Image control
	input wire logic present_i,
	input wire logic [7:0] tag_i
);
	// ----------------------------------------
	// Slave state
	// ----------------------------------------
	logic [7:0] sh;
	logic [7:0] cur;
	logic [15:0] ptr;
	logic act;
	logic rd;
	int bitn;
	int nbyte;
	initial begin
		pull_o = 1'b0;
		act = 1'b0;
		ptr = 16'h0;
	end
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = present_i;
			bitn = -1;
			nbyte = 0;
			rd = 1'b0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b0;
			pull_o = 1'b0;
		end
	end
	// A master that refuses a data byte ends the read.
	always @(posedge scl_i) begin
		if (act && bitn < 8) sh = {sh[6:0], sda_i};
		else if (act && rd && nbyte > 0 && sda_i) act = 1'b0;
	end
	always @(negedge scl_i) begin
		if (act) begin
			if (bitn == 8) begin
				bitn = 0;
				if (rd && nbyte > 0) ptr = ptr + 16'h1;
				nbyte = nbyte + 1;
			end else begin
				bitn = bitn + 1;
			end
			if (bitn == 8 && nbyte == 0) begin
				rd = sh[0];
				act = (sh[7:1] == 7'h50);
			end
			if (bitn == 8 && !rd && nbyte == 1) ptr[15:8] = sh;
			if (bitn == 8 && !rd && nbyte == 2) ptr[7:0] = sh;
			cur = (ptr == 16'h0) ? tag_i : {ptr[3:0], ~ptr[3:0]};
			if (bitn == 8) pull_o = (nbyte == 0) ? act : !rd;
			else pull_o = rd && nbyte > 0 && !cur[7 - bitn];
		end
	end
endmodule : eeprom_model
`default_nettype wire

//--- verif/pcie_config_autoload_test.sv
// Self-checking bench for the configuration autoloader.
`timescale 1ns/1ps
`default_nettype none
module pcie_config_autoload_test;
	// ----------------------------------------
	// Stimulus and wiring
	// ----------------------------------------
	localparam logic [31:0] DEF_ID = 32'h2e1a_1d0f; // Arbitrary value.
	localparam logic [31:0] DEF_SUB = 32'h5a3e_4b2d; // Arbitrary value.
	localparam logic [23:0] CLASS = 24'h070002;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] soft_rst = 3'h0;
	logic aux = 1'b0;
	logic [7:0] evt = 8'h00;
	logic [7:0] sevt = 8'h00;
	logic [31:0] strap = 32'h0000_aaaa;
	logic req = 1'b0;
	logic we = 1'b0;
	logic [11:0] addr = 12'h0;
	logic [31:0] wdata = 32'h0;
	logic present = 1'b0;
	logic [7:0] tag = 8'h55;
	logic scl, sda_o, oe_n, pull, ack, ext, ready, from_ee;
	logic [31:0] rdata;
	wire logic sda;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	assign sda = (!oe_n || pull) ? 1'b0 : 1'b1;
	always #4 clk_sys_i = ~clk_sys_i;
	pcie_config_autoload #(.DEF_VENDOR_ID(DEF_ID[15:0]), .DEF_DEVICE_ID(DEF_ID[31:16]), .DEF_REVISION(8'h3c),
		.DEF_SUB_VENDOR_ID(DEF_SUB[15:0]), .DEF_SUB_ID(DEF_SUB[31:16]), .CLASS_CODE(CLASS), .QTR_CYC(16),
		.EVT_W(8)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .hot_reset_i(soft_rst[0]), .warm_reset_i(soft_rst[1]),
		.cold_reset_i(soft_rst[2]), .aux_power_i(aux), .eeprom_scl_o(scl), .eeprom_sda_i(sda),
		.eeprom_sda_o(sda_o), .eeprom_sda_oe_n_o(oe_n), .status_evt_i(evt), .sticky_evt_i(sevt),
		.sticky_ro_strap_i(strap), .cfg_req_i(req), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
		.cfg_ack_o(ack), .cfg_rdata_o(rdata), .cfg_ext_o(ext), .cfg_ready_o(ready), .load_from_eeprom_o(from_ee));
	eeprom_model eep (.scl_i(scl), .sda_i(sda), .pull_o(pull), .present_i(present), .tag_i(tag));
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 40000) begin
			n_errors++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Requests may wait for the whole load, so the bound covers it.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		@(negedge clk_sys_i);
		req = 1'b1;
		we = w;
		addr = a;
		wdata = d;
		k = 0;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (ack !== 1'b1 && k < 20000);
		q = rdata;
		@(negedge clk_sys_i);
		req = 1'b0;
	endtask : xfer
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask : rd
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask : wr
	task automatic ids(input logic ee);
		rd(cfg_autoload_pkg::OFS_ID, ee ? 32'h4b3c_2d1e : DEF_ID);
		rd(cfg_autoload_pkg::OFS_REV, {CLASS, ee ? 8'h5a : 8'h3c});
		rd(cfg_autoload_pkg::OFS_SUB, ee ? 32'h9687_7869 : DEF_SUB);
		chk({31'h0, from_ee}, {31'h0, ee});
		chk({31'h0, ready}, 32'h1);
	endtask : ids
	task automatic por(input logic p, input logic [7:0] t);
		@(negedge clk_sys_i);
		rst_i = 1'b1;
		present = p;
		tag = t;
		repeat (10) @(negedge clk_sys_i);
		rst_i = 1'b0;
	endtask : por
	task automatic softp(input logic [2:0] v);
		@(negedge clk_sys_i);
		soft_rst = v;
		repeat (3) @(negedge clk_sys_i);
		soft_rst = 3'h0;
	endtask : softp
	initial begin
		por(1'b0, 8'h55);
		ids(1'b0);
		$display("test absent done");
		por(1'b1, 8'haa);
		ids(1'b0);
		$display("test bad tag done");
		por(1'b1, 8'h55);
		ids(1'b1);
		$display("test eeprom load done");
		wr(cfg_autoload_pkg::OFS_RW, 32'ha5a5_5a5a);
		rd(cfg_autoload_pkg::OFS_RW, 32'ha5a5_5a5a);
		wr(cfg_autoload_pkg::OFS_RW, 32'ha5a5_5a3c);
		rd(cfg_autoload_pkg::OFS_RW, 32'ha5a5_5a3c);
		wr(cfg_autoload_pkg::OFS_SRW, 32'h1234_5678);
		@(negedge clk_sys_i);
		evt = 8'h0f;
		sevt = 8'hf0;
		@(negedge clk_sys_i);
		evt = 8'h00;
		sevt = 8'h00;
		rd(cfg_autoload_pkg::OFS_W1C, 32'h0f);
		wr(cfg_autoload_pkg::OFS_W1C, 32'h05);
		rd(cfg_autoload_pkg::OFS_W1C, 32'h0a);
		wr(cfg_autoload_pkg::OFS_W1C, 32'h00);
		rd(cfg_autoload_pkg::OFS_W1C, 32'h0a);
		wr(cfg_autoload_pkg::OFS_SW1C, 32'h30);
		rd(cfg_autoload_pkg::OFS_SW1C, 32'hc0);
		wr(cfg_autoload_pkg::OFS_ID, 32'hffff_ffff);
		wr(cfg_autoload_pkg::OFS_SRO, 32'h0);
		ids(1'b1);
		rd(cfg_autoload_pkg::OFS_SRO, 32'h0000_aaaa);
		strap = 32'h0000_5555;
		softp(3'h1);
		rd(cfg_autoload_pkg::OFS_RW, 32'h0);
		rd(cfg_autoload_pkg::OFS_W1C, 32'h0);
		rd(cfg_autoload_pkg::OFS_SRW, 32'h1234_5678);
		rd(cfg_autoload_pkg::OFS_SW1C, 32'hc0);
		rd(cfg_autoload_pkg::OFS_SRO, 32'h0000_aaaa);
		aux = 1'b1;
		softp(3'h2);
		rd(cfg_autoload_pkg::OFS_SRW, 32'h1234_5678);
		rd(cfg_autoload_pkg::OFS_SW1C, 32'hc0);
		rd(cfg_autoload_pkg::OFS_SRO, 32'h0000_aaaa);
		aux = 1'b0;
		softp(3'h4);
		rd(cfg_autoload_pkg::OFS_SRW, 32'h0);
		rd(cfg_autoload_pkg::OFS_SW1C, 32'h0);
		rd(cfg_autoload_pkg::OFS_SRO, 32'h0000_5555);
		rd(12'hffc, 32'h0);
		chk({31'h0, ext}, 32'h1);
		rd(12'h0fc, 32'h0);
		chk({31'h0, ext}, 32'h0);
		$display("test registers done");
		results();
	end
endmodule : pcie_config_autoload_test
`default_nettype wire
